// [hw/uaec_main.sv]
// Purpose: Automatic DMA supervisor: event flags, mask, mirror, countdown
// Assumes: Endpoint and DMA logic on the same clock give one-cycle pulses
// Notes: The four low flags clear by writing zero; hardware set wins over a clear
`timescale 1ns/1ps
`default_nettype none
module uaec_main (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [2:0] cpu_addr,
  input wire logic cpu_wr,
  input wire logic cpu_rd,
  input wire logic [7:0] cpu_wdata,
  output logic [7:0] cpu_rdata,
  input wire logic automatic_transfer_mode,
  input wire logic [2:0] source_endpoint_select,
  input wire logic ignore_receive_parity_compare,
  input wire logic initial_toggle_write,
  input wire logic initial_toggle_control,
  input wire logic iso_mode,
  input wire logic usb_busy,
  input wire logic flush_done,
  input wire logic dma_busy,
  input wire logic pkt_done,
  input wire logic pkt_error,
  input wire logic pkt_toggle,
  input wire logic pkt_short,
  input wire logic xfer_complete,
  input wire logic [47:0] endpoint_status_flat,
  output logic endpoint_flush_req,
  output logic automatic_transfer_mode_active,
  output logic auto_mode_ready_flag,
  output logic next_toggle_bit,
  output logic tx_toggle_override,
  output logic tx_toggle_value,
  output logic tx_reload_req,
  output logic rx_flush_req,
  output logic iso_discard_req,
  output logic alternate_event_summary
);
  typedef struct packed {
    uaec_pkg::uaec_state_type state;
    logic halt_sw;
    logic [5:0] flags;
    logic [7:0] mask;
    logic [7:0] mirror;
    logic [7:0] count;
    logic auto_error_handling;
    logic [7:0] rdata;
    logic tx_reload;
    logic rx_flush;
    logic iso_discard;
  } uaec_regs_type;

  uaec_regs_type s_r;
  uaec_regs_type s_nxt;

  logic [6:0] err_preset;
  logic [6:0] err_work;
  logic err_at_zero;
  logic err_preset_wr;
  logic err_load;
  logic err_dec;

  function automatic logic wr_hit(input logic [2:0] idx);
    wr_hit = cpu_wr && (cpu_addr == idx);
  endfunction

  function automatic logic [7:0] ep_status(input logic [2:0] sel);
    logic [7:0] v;
    v = uaec_pkg::MIRROR_RESET;
    for (int i = 0; i < uaec_pkg::NUM_EP; i++) begin
      if (sel == 3'(i)) begin
        v = endpoint_status_flat[i*uaec_pkg::STAT_W +: uaec_pkg::STAT_W];
      end
    end
    ep_status = v;
  endfunction

  // Odd endpoints transmit, even ones receive; code 0 is endpoint one
  logic is_rx;
  logic running;
  logic low_set;
  logic tgl_bad;
  logic err_hit;
  logic good_pkt;
  logic [5:0] set_ev;

  assign is_rx = source_endpoint_select[0];
  assign running = (s_r.state == uaec_pkg::ST_RUN);
  assign low_set = |(s_r.flags & uaec_pkg::EV_LOW_MASK);
  // Toggle compared with the current next toggle, before it flips
  assign tgl_bad = (pkt_toggle != s_r.flags[uaec_pkg::EV_TGL])
    && !(is_rx && ignore_receive_parity_compare);
  assign err_hit = running && pkt_done && (pkt_error || tgl_bad);
  assign good_pkt = running && pkt_done && !err_hit;

  always_comb begin
    s_nxt = s_r;
    set_ev = 6'h00;
    err_load = 1'b0;
    err_dec = 1'b0;
    s_nxt.tx_reload = 1'b0;
    s_nxt.rx_flush = 1'b0;
    s_nxt.iso_discard = 1'b0;

    // Engine sequencing
    case (s_r.state)
      uaec_pkg::ST_IDLE: begin
        if (automatic_transfer_mode && !low_set) begin
          s_nxt.state = uaec_pkg::ST_FLUSH;
        end
      end
      uaec_pkg::ST_FLUSH: begin
        if (!automatic_transfer_mode) begin
          s_nxt.state = uaec_pkg::ST_IDLE;
        end else if (!usb_busy && flush_done) begin
          s_nxt.state = uaec_pkg::ST_RUN;
          err_load = 1'b1;
        end
      end
      uaec_pkg::ST_RUN: begin
        if (!automatic_transfer_mode) begin
          s_nxt.state = uaec_pkg::ST_DRAIN;
          s_nxt.halt_sw = 1'b1;
        end else if (low_set) begin
          s_nxt.state = uaec_pkg::ST_DRAIN;
        end
      end
      uaec_pkg::ST_DRAIN: begin
        // Ready stays up until the current DMA operation completes
        if (!dma_busy) begin
          s_nxt.state = uaec_pkg::ST_IDLE;
          s_nxt.halt_sw = 1'b0;
          err_load = 1'b1;
          if (s_r.halt_sw) begin
            set_ev[uaec_pkg::EV_HALT] = 1'b1;
          end
        end
      end
      default: begin
        s_nxt.state = uaec_pkg::ST_IDLE;
      end
    endcase

    // Failed packets and automatic retry
    if (err_hit) begin
      if (!s_r.auto_error_handling) begin
        set_ev[uaec_pkg::EV_ERR] = 1'b1;
      end else if (err_at_zero) begin
        set_ev[uaec_pkg::EV_ERR] = 1'b1;
      end else begin
        err_dec = 1'b1;
        if (iso_mode) begin
          s_nxt.iso_discard = is_rx;
        end else begin
          s_nxt.tx_reload = !is_rx;
          s_nxt.rx_flush = is_rx;
        end
      end
    end
    if (good_pkt) begin
      err_load = 1'b1;
      if (is_rx && pkt_short) begin
        set_ev[uaec_pkg::EV_SIZE] = 1'b1;
      end
    end

    // Countdown; the whole operation is reported by xfer_complete
    if (wr_hit(uaec_pkg::ADDR_COUNT)) begin
      s_nxt.count = cpu_wdata;
    end else if (running && xfer_complete) begin
      if (s_r.count == uaec_pkg::BYTE_ZERO) begin
        set_ev[uaec_pkg::EV_CNT] = 1'b1;
      end else begin
        s_nxt.count = s_r.count - uaec_pkg::COUNT_STEP;
      end
    end

    // Sticky flags: write zero clears, write one keeps, set wins
    if (wr_hit(uaec_pkg::ADDR_EVENT)) begin
      s_nxt.flags = s_r.flags & (cpu_wdata[5:0] | ~uaec_pkg::EV_CLEAR_MASK);
    end
    s_nxt.flags = s_nxt.flags | set_ev;
    s_nxt.flags[uaec_pkg::EV_RDY] = (s_nxt.state == uaec_pkg::ST_RUN) ||
      (s_nxt.state == uaec_pkg::ST_DRAIN);

    if (initial_toggle_write) begin
      s_nxt.flags[uaec_pkg::EV_TGL] = initial_toggle_control;
    end else if (good_pkt) begin
      s_nxt.flags[uaec_pkg::EV_TGL] = !s_r.flags[uaec_pkg::EV_TGL];
    end

    if (wr_hit(uaec_pkg::ADDR_MASK)) begin
      s_nxt.mask = cpu_wdata;
    end
    if (wr_hit(uaec_pkg::ADDR_ERROR) &&
        s_r.state == uaec_pkg::ST_IDLE) begin
      s_nxt.auto_error_handling = cpu_wdata[7];
    end

    // Mirror is a plain copy, so reading it clears nothing upstream
    if (source_endpoint_select <= uaec_pkg::SRC_LAST_CODE) begin
      s_nxt.mirror = ep_status(source_endpoint_select);
    end else begin
      s_nxt.mirror = uaec_pkg::MIRROR_RESET;
    end

    if (cpu_rd) begin
      case (cpu_addr)
        uaec_pkg::ADDR_EVENT: s_nxt.rdata = {2'b00, s_r.flags};
        uaec_pkg::ADDR_MASK: s_nxt.rdata = s_r.mask;
        uaec_pkg::ADDR_MIRROR: s_nxt.rdata = s_r.mirror;
        uaec_pkg::ADDR_COUNT: s_nxt.rdata = s_r.count;
        uaec_pkg::ADDR_ERROR: begin
          if (s_r.state == uaec_pkg::ST_IDLE) begin
            s_nxt.rdata = {s_r.auto_error_handling, err_preset};
          end else begin
            s_nxt.rdata = {s_r.auto_error_handling, err_work};
          end
        end
        default: s_nxt.rdata = uaec_pkg::BYTE_ZERO;
      endcase
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s_r <= '0;
      s_r.state <= uaec_pkg::ST_IDLE;
      s_r.mirror <= uaec_pkg::MIRROR_RESET;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign err_preset_wr = wr_hit(uaec_pkg::ADDR_ERROR) &&
    (s_r.state == uaec_pkg::ST_IDLE);

  uaec_errcnt u_errcnt (
    .clk(clk),
    .reset_n(reset_n),
    .preset_wr(err_preset_wr),
    .preset_val(cpu_wdata[6:0]),
    .load(err_load),
    .dec(err_dec),
    .preset(err_preset),
    .work(err_work),
    .at_zero(err_at_zero)
  );

  assign cpu_rdata = s_r.rdata;
  assign endpoint_flush_req = (s_r.state == uaec_pkg::ST_FLUSH);
  assign automatic_transfer_mode_active = (s_r.state != uaec_pkg::ST_IDLE);
  assign auto_mode_ready_flag = s_r.flags[uaec_pkg::EV_RDY];
  assign next_toggle_bit = s_r.flags[uaec_pkg::EV_TGL];
  assign tx_toggle_override = running && !is_rx;
  assign tx_toggle_value = s_r.flags[uaec_pkg::EV_TGL];
  assign tx_reload_req = s_r.tx_reload;
  assign rx_flush_req = s_r.rx_flush;
  assign iso_discard_req = s_r.iso_discard;
  // Next toggle has no mask bit and is kept out of the summary
  assign alternate_event_summary =
    |(s_r.mask[4:0] & s_r.flags[4:0]);

  halt_after_idle_a: assert property (@(posedge clk)
    disable iff (!reset_n)
    $rose(s_r.flags[uaec_pkg::EV_HALT]) |->
      ($past(s_r.state) == uaec_pkg::ST_DRAIN) && $past(s_r.halt_sw) &&
      (s_r.state == uaec_pkg::ST_IDLE))
    else $error("halt flag set before engine idle");

  no_start_a: assert property (@(posedge clk) disable iff (!reset_n)
    (s_r.state == uaec_pkg::ST_IDLE && low_set) |=>
      (s_r.state == uaec_pkg::ST_IDLE))
    else $error("automatic mode started with flags set");

  auto_stop_a: assert property (@(posedge clk) disable iff (!reset_n)
    (running && low_set) |=> (s_r.state == uaec_pkg::ST_DRAIN))
    else $error("automatic mode kept running with flags set");

  count_write_a: assert property (@(posedge clk) disable iff (!reset_n)
    wr_hit(uaec_pkg::ADDR_COUNT) |=> (s_r.count == $past(cpu_wdata)))
    else $error("countdown write lost");

  count_floor_a: assert property (@(posedge clk) disable iff (!reset_n)
    (running && xfer_complete && s_r.count == uaec_pkg::BYTE_ZERO &&
     !wr_hit(uaec_pkg::ADDR_COUNT)) |=>
      (s_r.count == uaec_pkg::BYTE_ZERO) && s_r.flags[uaec_pkg::EV_CNT])
    else $error("countdown underflow or missing count flag");

  toggle_load_a: assert property (@(posedge clk) disable iff (!reset_n)
    initial_toggle_write |=>
      (s_r.flags[uaec_pkg::EV_TGL] == $past(initial_toggle_control)))
    else $error("next toggle not loaded by toggle write");

  err_write_lock_a: assert property (@(posedge clk)
    disable iff (!reset_n)
    (wr_hit(uaec_pkg::ADDR_ERROR) && automatic_transfer_mode_active) |=>
      $stable(err_preset) && $stable(s_r.auto_error_handling))
    else $error("error register written while active");

  summary_mask_a: assert property (@(posedge clk)
    disable iff (!reset_n)
    (s_r.flags[uaec_pkg::EV_ERR] && s_r.mask[uaec_pkg::EV_ERR])
      |-> alternate_event_summary)
    else $error("masked-in error flag missing from summary");

  flag_clear_a: assert property (@(posedge clk) disable iff (!reset_n)
    (wr_hit(uaec_pkg::ADDR_EVENT) && cpu_wdata[uaec_pkg::EV_SIZE] &&
     !s_r.flags[uaec_pkg::EV_SIZE] && !pkt_done) |=>
      !s_r.flags[uaec_pkg::EV_SIZE])
    else $error("writing one set a flag");

  aeh_hold_a: assert property (@(posedge clk) disable iff (!reset_n)
    (err_hit && s_r.auto_error_handling && !err_at_zero && !s_r.flags[uaec_pkg::EV_ERR] &&
     !wr_hit(uaec_pkg::ADDR_EVENT)) |=> !s_r.flags[uaec_pkg::EV_ERR])
    else $error("error flag set before counter reached zero");
endmodule // uaec_main
`default_nettype wire

// [hw/uaec_pkg.sv]
// Purpose: Shared constants and types of the automatic DMA event control
// Assumes: One CPU clock, registers reached by a small local index bus
// Notes: Register indices are local word selects, not byte addresses
package uaec_pkg;
  localparam logic [2:0] ADDR_EVENT = 3'h0;
  localparam logic [2:0] ADDR_MASK = 3'h1;
  localparam logic [2:0] ADDR_MIRROR = 3'h2;
  localparam logic [2:0] ADDR_COUNT = 3'h3;
  localparam logic [2:0] ADDR_ERROR = 3'h4;
  localparam int EV_HALT = 0;
  localparam int EV_ERR = 1;
  localparam int EV_CNT = 2;
  localparam int EV_SIZE = 3;
  localparam int EV_RDY = 4;
  localparam int EV_TGL = 5;
  localparam int EV_W = 6;
  localparam logic [5:0] EV_LOW_MASK = 6'h0F;
  localparam logic [5:0] EV_CLEAR_MASK = 6'h0F;
  localparam logic [7:0] MIRROR_RESET = 8'h1F;
  localparam int ERRCNT_W = 7;
  localparam int NUM_EP = 6;
  localparam int STAT_W = 8;
  localparam logic [2:0] SRC_LAST_CODE = 3'h5;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [7:0] COUNT_STEP = 8'h01;
  localparam logic [6:0] ERR_STEP = 7'h01;
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_FLUSH,
    ST_RUN,
    ST_DRAIN
  } uaec_state_type;
endpackage

// [hw/uaec_errcnt.sv]
// Purpose: Consecutive error counter with stored preset and working copy
// Assumes: Caller gates preset writes while the automatic mode is active
// Notes: Load of the working copy wins over a decrement in the same cycle
`timescale 1ns/1ps
`default_nettype none
module uaec_errcnt (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic preset_wr,
  input wire logic [6:0] preset_val,
  input wire logic load,
  input wire logic dec,
  output logic [6:0] preset,
  output logic [6:0] work,
  output logic at_zero
);
  typedef struct packed {
    logic [6:0] preset;
    logic [6:0] work;
  } uaec_cnt_type;

  uaec_cnt_type s_r;
  uaec_cnt_type s_nxt;

  always_comb begin
    s_nxt = s_r;
    if (preset_wr) begin
      s_nxt.preset = preset_val;
    end
    if (load) begin
      s_nxt.work = s_r.preset;
    end else if (dec && s_r.work != 7'h00) begin
      s_nxt.work = s_r.work - uaec_pkg::ERR_STEP;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign preset = s_r.preset;
  assign work = s_r.work;
  assign at_zero = (s_r.work == 7'h00);

  no_underrun_a: assert property (@(posedge clk) disable iff (!reset_n)
    (dec && !load) |=> (s_r.work == (($past(s_r.work) == 7'h00) ? 7'h00 :
      $past(s_r.work) - uaec_pkg::ERR_STEP)))
    else $error("error counter ran below zero");

  reload_preset_a: assert property (@(posedge clk) disable iff (!reset_n)
    load |=> (s_r.work == $past(s_r.preset)))
    else $error("working counter not loaded from preset");
endmodule // uaec_errcnt
`default_nettype wire

// [verification/uaec_far_model.sv]
// Purpose: Far side model: endpoint flush, USB traffic, DMA activity
// Assumes: Flush completes a few cycles after it is requested
// Notes: Slow mode holds the bus busy for the first two flush cycles and stretches the flush
`timescale 1ns/1ps
`default_nettype none
module uaec_far_model (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic slow,
  input wire logic endpoint_flush_req,
  input wire logic pkt_done,
  input wire logic pkt_error,
  input wire logic xfer_complete,
  output logic usb_busy,
  output logic flush_done,
  output logic dma_busy,
  output logic [47:0] endpoint_status_flat
);
  logic [2:0] cnt_r;
  // Distinct byte per endpoint so a wrong select shows at once
  assign endpoint_status_flat = 48'h262524232221;
  assign usb_busy = slow & endpoint_flush_req & (cnt_r < 3'h2);
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_r <= 3'h0;
      flush_done <= 1'b0;
      dma_busy <= 1'b0;
    end else begin
      cnt_r <= endpoint_flush_req ? cnt_r + {2'h0, cnt_r != 3'h7} : 3'h0;
      flush_done <= endpoint_flush_req && cnt_r >= (slow ? 3'h4 : 3'h0);
      // Memory move runs from a good packet until its completion
      if (pkt_done && !pkt_error) dma_busy <= 1'b1;
      else if (xfer_complete) dma_busy <= 1'b0;
    end
  end
endmodule // uaec_far_model
`default_nettype wire

// [verification/tb.sv]
// Purpose: Self-checking bench of the automatic DMA supervisor
// Assumes: Inputs change on the falling edge only
// Notes: Event reads after the register step are masked to the four low flags
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk, reset_n, cpu_wr, cpu_rd, automatic_transfer_mode, slow;
  logic [2:0] cpu_addr, source_endpoint_select;
  logic [7:0] cpu_wdata, cpu_rdata, r;
  logic ignore_receive_parity_compare, initial_toggle_write;
  logic initial_toggle_control, iso_mode, usb_busy, flush_done, dma_busy;
  logic pkt_done, pkt_error, pkt_toggle, pkt_short, xfer_complete;
  logic [47:0] endpoint_status_flat;
  logic endpoint_flush_req, automatic_transfer_mode_active, auto_mode_ready_flag;
  logic next_toggle_bit, tx_toggle_override, tx_toggle_value;
  logic tx_reload_req, rx_flush_req, iso_discard_req;
  logic alternate_event_summary;
  int fail_count = 0, cmp_count = 0, cyc = 0;
  uaec_main u_uaec_main (.clk, .reset_n, .cpu_addr, .cpu_wr, .cpu_rd,
    .cpu_wdata, .cpu_rdata, .automatic_transfer_mode,
    .source_endpoint_select, .ignore_receive_parity_compare,
    .initial_toggle_write, .initial_toggle_control, .iso_mode, .usb_busy,
    .flush_done, .dma_busy, .pkt_done, .pkt_error, .pkt_toggle, .pkt_short,
    .xfer_complete, .endpoint_status_flat, .endpoint_flush_req,
    .automatic_transfer_mode_active, .auto_mode_ready_flag, .next_toggle_bit,
    .tx_toggle_override, .tx_toggle_value, .tx_reload_req, .rx_flush_req,
    .iso_discard_req, .alternate_event_summary);
  uaec_far_model u_uaec_far_model (.clk, .reset_n, .slow,
    .endpoint_flush_req, .pkt_done, .pkt_error, .xfer_complete, .usb_busy,
    .flush_done, .dma_busy, .endpoint_status_flat);
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk8(string n, logic [7:0] e, logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      fail_count++;
      $display("unexpected %s: expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chk1(string n, logic e, logic g);
    chk8(n, {7'h00, e}, {7'h00, g});
  endtask
  task automatic wr(logic [2:0] a, logic [7:0] d);
    @(negedge clk);
    cpu_addr = a;
    cpu_wdata = d;
    cpu_wr = 1'b1;
    @(negedge clk);
    cpu_wr = 1'b0;
  endtask
  task automatic rd(logic [2:0] a);
    @(negedge clk);
    cpu_addr = a;
    cpu_rd = 1'b1;
    @(negedge clk);
    cpu_rd = 1'b0;
    r = cpu_rdata;
  endtask
  task automatic pkt(logic e, logic t, logic s);
    @(negedge clk);
    pkt_done = 1'b1;
    pkt_error = e;
    pkt_toggle = t;
    pkt_short = s;
    @(negedge clk);
    pkt_done = 1'b0;
  endtask
  task automatic xc();
    @(negedge clk);
    xfer_complete = 1'b1;
    @(negedge clk);
    xfer_complete = 1'b0;
  endtask
  task automatic tgl(logic v);
    initial_toggle_control = v;
    initial_toggle_write = 1'b1;
    @(negedge clk);
    initial_toggle_write = 1'b0;
  endtask
  task automatic go(logic [2:0] s);
    source_endpoint_select = s;
    // Automatic transfer mode is raised here and left up until idle(), except that t_toggle drops it directly to test the drain
    automatic_transfer_mode = 1'b1;
    @(negedge clk);
    chk1("flush req", 1'b1, endpoint_flush_req);
    for (int i = 0; i < 20 && !auto_mode_ready_flag; i++) @(negedge clk);
    chk1("ready", 1'b1, auto_mode_ready_flag);
  endtask
  task automatic idle();
    automatic_transfer_mode = 1'b0;
    for (int i = 0; i < 20 && automatic_transfer_mode_active; i++) @(negedge clk);
  endtask
  task automatic t_regs();
    rd(uaec_pkg::ADDR_EVENT);
    chk8("events", 8'h00, r);
    rd(uaec_pkg::ADDR_COUNT);
    chk8("count", 8'h00, r);
    wr(uaec_pkg::ADDR_EVENT, 8'hFF);
    rd(uaec_pkg::ADDR_EVENT);
    chk8("events set", 8'h00, r);
    wr(uaec_pkg::ADDR_MASK, 8'h5A);
    rd(uaec_pkg::ADDR_MASK);
    chk8("mask", 8'h5A, r);
    rd(3'h7);
    chk8("unmapped", 8'h00, r);
    for (int c = 0; c < 8; c++) begin
      source_endpoint_select = c[2:0];
      repeat (2) @(negedge clk);
      rd(uaec_pkg::ADDR_MIRROR);
      chk8("mirror", c < 6 ? 8'h21 + c[7:0] : 8'h1F, r);
    end
    $display("registers done");
  endtask
  task automatic t_count();
    wr(uaec_pkg::ADDR_COUNT, 8'h01);
    wr(uaec_pkg::ADDR_MASK, 8'h04);
    go(3'h0);
    xc();
    rd(uaec_pkg::ADDR_COUNT);
    chk8("count", 8'h00, r);
    rd(uaec_pkg::ADDR_EVENT);
    chk8("flag early", 8'h00, r & 8'h0F);
    chk1("summary", 1'b0, alternate_event_summary);
    xc();
    chk1("summary", 1'b1, alternate_event_summary);
    repeat (3) @(negedge clk);
    chk1("active", 1'b0, automatic_transfer_mode_active);
    chk1("summary idle", 1'b1, alternate_event_summary);
    wr(uaec_pkg::ADDR_MASK, 8'h00);
    chk1("masked", 1'b0, alternate_event_summary);
    rd(uaec_pkg::ADDR_EVENT);
    chk8("count flag", 8'h04, r & 8'h0F);
    chk1("refused", 1'b0, automatic_transfer_mode_active);
    idle();
    wr(uaec_pkg::ADDR_EVENT, 8'h00);
    $display("countdown done");
  endtask
  task automatic t_toggle();
    tgl(1'b1);
    chk1("next toggle", 1'b1, next_toggle_bit);
    go(3'h0);
    chk1("override", 1'b1, tx_toggle_override);
    chk1("tx toggle", 1'b1, tx_toggle_value);
    @(negedge clk);
    cpu_addr = uaec_pkg::ADDR_COUNT;
    cpu_wdata = 8'h07;
    cpu_wr = 1'b1;
    xfer_complete = 1'b1;
    @(negedge clk);
    cpu_wr = 1'b0;
    xfer_complete = 1'b0;
    rd(uaec_pkg::ADDR_COUNT);
    chk8("count", 8'h07, r);
    pkt(1'b0, 1'b1, 1'b1);
    chk1("next toggle", 1'b0, next_toggle_bit);
    initial_toggle_control = 1'b1;
    initial_toggle_write = 1'b1;
    // Packet carries the toggle the first write edge set, so only the flip
    // competes with the write at the second edge
    pkt(1'b0, 1'b1, 1'b0);
    initial_toggle_write = 1'b0;
    chk1("toggle write", 1'b1, next_toggle_bit);
    rd(uaec_pkg::ADDR_EVENT);
    chk8("events", 8'h00, r & 8'h0F);
    automatic_transfer_mode = 1'b0;
    repeat (2) @(negedge clk);
    chk1("ready drain", 1'b1, auto_mode_ready_flag);
    rd(uaec_pkg::ADDR_EVENT);
    chk8("halt early", 8'h00, r & 8'h0F);
    xc();
    repeat (2) @(negedge clk);
    chk1("ready", 1'b0, auto_mode_ready_flag);
    rd(uaec_pkg::ADDR_EVENT);
    chk8("halt", 8'h01, r & 8'h0F);
    wr(uaec_pkg::ADDR_EVENT, 8'h00);
    $display("toggle and halt done");
  endtask
  task automatic t_tx_err();
    wr(uaec_pkg::ADDR_ERROR, 8'h81);
    go(3'h0);
    rd(uaec_pkg::ADDR_ERROR);
    chk8("error live", 8'h81, r);
    pkt(1'b1, 1'b0, 1'b0);
    chk1("reload", 1'b1, tx_reload_req);
    rd(uaec_pkg::ADDR_ERROR);
    chk8("error live", 8'h80, r);
    wr(uaec_pkg::ADDR_ERROR, 8'hFF);
    rd(uaec_pkg::ADDR_ERROR);
    chk8("error locked", 8'h80, r);
    pkt(1'b1, 1'b0, 1'b0);
    chk1("reload", 1'b0, tx_reload_req);
    rd(uaec_pkg::ADDR_EVENT);
    chk8("error flag", 8'h02, r & 8'h0F);
    idle();
    rd(uaec_pkg::ADDR_ERROR);
    chk8("error preset", 8'h81, r);
    wr(uaec_pkg::ADDR_EVENT, 8'h00);
    $display("transmit errors done");
  endtask
  task automatic t_rx();
    slow = 1'b1;
    wr(uaec_pkg::ADDR_ERROR, 8'h82);
    tgl(1'b0);
    go(3'h1);
    pkt(1'b1, 1'b0, 1'b0);
    chk1("rx flush", 1'b1, rx_flush_req);
    iso_mode = 1'b1;
    pkt(1'b1, 1'b0, 1'b0);
    chk1("discard", 1'b1, iso_discard_req);
    iso_mode = 1'b0;
    ignore_receive_parity_compare = 1'b1;
    pkt(1'b0, 1'b1, 1'b0);
    chk1("rx flush", 1'b0, rx_flush_req);
    chk1("active", 1'b1, automatic_transfer_mode_active);
    ignore_receive_parity_compare = 1'b0;
    pkt(1'b0, 1'b0, 1'b0);
    chk1("rx flush", 1'b1, rx_flush_req);
    pkt(1'b0, 1'b1, 1'b1);
    rd(uaec_pkg::ADDR_EVENT);
    chk8("short", 8'h08, r & 8'h0F);
    xc();
    idle();
    chk1("active", 1'b0, automatic_transfer_mode_active);
    wr(uaec_pkg::ADDR_EVENT, 8'h00);
    $display("receive done");
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      fail_count++;
      summarize();
    end
  end
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    {reset_n, cpu_wr, cpu_rd, automatic_transfer_mode, slow} = '0;
    {cpu_addr, source_endpoint_select, cpu_wdata} = '0;
    {ignore_receive_parity_compare, initial_toggle_write} = '0;
    {initial_toggle_control, iso_mode, pkt_done, pkt_error} = '0;
    {pkt_toggle, pkt_short, xfer_complete} = '0;
    repeat (6) @(negedge clk);
    reset_n = 1'b1;
    t_regs();
    t_count();
    t_toggle();
    t_tx_err();
    t_rx();
    summarize();
  end
endmodule // tb
`default_nettype wire
